// file: llbs_defines.svh
// Constants of the low-latency bypass select block.
// Operation
// R1: Any reset returns the block to low-latency state, processing out of path.
// R2: Low-latency state forwards raw samples with exactly 10 clocks latency.
// R3: Low-latency state ignores test pattern, gain and offset settings.
// R4: Processed path adds pipeline clocks beyond the raw-path latency.
// R5: Host sets the fast-path-off bit before programming any digital function.
// R6: Each serial transfer is an 8-bit address then 8 bits of data.
// R7: Setting fast-path-off enables gain at 0 dB until a code is written.
// R8: Offset correction is off after reset; host enables it after leaving.
// R9: Output multiplexer follows the current fast-path-off bit.
`ifndef LLBS_DEFINES_SVH
`define LLBS_DEFINES_SVH

// ---------------------------------------------------------------------------
// Timing
// ---------------------------------------------------------------------------
`define LLBS_LL_CYCLES    10
`define LLBS_PROC_CYCLES  4
`define LLBS_GAIN_FRAC    12
`define LLBS_EST_FRAC     20
`define LLBS_TC_BASE      5'h08
`define LLBS_TC_MAX       4'hb

// ---------------------------------------------------------------------------
// Serial register map
// ---------------------------------------------------------------------------
`define LLBS_ADDR_RESET   8'h00
`define LLBS_ADDR_PATH    8'h01
`define LLBS_ADDR_GAIN    8'h02
`define LLBS_ADDR_TRIM    8'h03
`define LLBS_ADDR_TEST    8'h04
`define LLBS_BIT_SRESET   0
`define LLBS_BIT_FPO      0
`define LLBS_BIT_TRIM_EN  0
`define LLBS_BIT_FREEZE   1
`define LLBS_TC_LSB       2
`define LLBS_GAIN_RST     4'h0
`define LLBS_TC_RST       4'h0
`define LLBS_XFER_BITS    16

`endif

// file: llbs_fifo.sv
// Output word FIFO with honest full and empty and an early space flag.
`timescale 1ns/1ns
module llbs_fifo #(
  parameter int DW    = 14,
  parameter int DEPTH = 16,
  parameter int SLACK = 14
) (
  input  wire logic  clk,
  input  wire logic  rst_n,
  llbs_stream_if.snk wr,
  llbs_stream_if.src rd,
  output logic       space_q
);
  localparam int AW = $clog2(DEPTH);

  logic [DW-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [AW:0]   count_q;
  logic [AW:0]   count_d;
  logic          push;
  logic          pop;

  assign wr.ready = (count_q != (AW+1)'(DEPTH));
  assign rd.valid = (count_q != '0);
  assign rd.data  = mem_q[rd_ptr_q];
  assign push     = wr.valid && wr.ready;
  assign pop      = rd.valid && rd.ready;

  always_comb begin
    count_d = count_q;
    if (push && !pop) begin
      count_d = count_q + 1'b1;
    end else if (pop && !push) begin
      count_d = count_q - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_ptr_q] <= wr.data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
      space_q  <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr_q <= (wr_ptr_q == AW'(DEPTH-1)) ? '0 : wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= (rd_ptr_q == AW'(DEPTH-1)) ? '0 : rd_ptr_q + 1'b1;
      end
      count_q <= count_d;
      // Space is withdrawn early enough to absorb every word still in flight.
      space_q <= (count_d < (AW+1)'(DEPTH - SLACK));
    end
  end
endmodule // llbs_fifo

// file: llbs_partner.sv
// Host serial writer and output capture receiver facing the block.
`timescale 1ns/1ns
module llbs_partner #(
  parameter int DW = 14
) (
  input  wire logic          clk,
  input  wire logic [DW-1:0] out_data,
  input  wire logic          out_valid,
  output logic               out_ready,
  output logic               sclk,
  output logic               sen_n,
  output logic               sdata
);
  int            cyc = 0;
  logic [DW-1:0] got_q[$];
  int            at_q[$];

  initial begin
    out_ready = 1'b1;
    sclk = 1'b0;
    sen_n = 1'b1;
    sdata = 1'b1;
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (out_valid && out_ready) begin
      got_q.push_back(out_data);
      at_q.push_back(cyc);
    end
  end

  // Four clocks per phase keep each serial clock level above three.
  task automatic write(input logic [7:0] a, input logic [7:0] d);
    logic [15:0] w;
    w = {a, d};
    sen_n <= 1'b0;
    repeat (4) @(posedge clk);
    for (int i = 15; i >= 0; i--) begin
      sdata <= w[i];
      repeat (4) @(posedge clk);
      sclk <= 1'b1;
      repeat (4) @(posedge clk);
      sclk <= 1'b0;
    end
    repeat (4) @(posedge clk);
    sen_n <= 1'b1;
    sdata <= ~w[0];
    repeat (8) @(posedge clk);
  endtask
endmodule // llbs_partner

// file: llbs_pkg.sv
// Types shared by the low-latency bypass select modules.
package llbs_pkg;

  // -------------------------------------------------------------------------
  // Serial receiver states, Gray coded along idle, shift, commit
  // -------------------------------------------------------------------------
  typedef enum logic [1:0] {
    SER_IDLE   = 2'h0,
    SER_SHIFT  = 2'h1,
    SER_COMMIT = 2'h3
  } ser_state_type;

  typedef enum logic [1:0] {
    TP_NONE  = 2'h0,
    TP_ZEROS = 2'h1,
    TP_ONES  = 2'h2,
    TP_RAMP  = 2'h3
  } test_mode_type;

endpackage

// file: llbs_properties.sv
// Port-level checks of the low-latency bypass select block.
`timescale 1ns/1ns
module llbs_properties #(
  parameter int DW = 14
) (
  input wire logic          CLK,
  input wire logic          RESET_N,
  input wire logic          SCLK,
  input wire logic          SEN_N,
  input wire logic          SDATA,
  input wire logic [DW-1:0] RAW_DATA,
  input wire logic          RAW_VALID,
  input wire logic          RAW_READY,
  input wire logic [DW-1:0] OUT_DATA,
  input wire logic          OUT_VALID,
  input wire logic          OUT_READY,
  input wire logic          LOW_LATENCY
);
  logic [5:0] pend_q;
  logic [5:0] pend_d;
  logic       take;
  logic       pop;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);

  assign take = RAW_VALID && RAW_READY;
  assign pop = OUT_VALID && OUT_READY;
  // Words taken but not yet delivered; an empty pipe makes latency exact.
  assign pend_d = pend_q + {5'h00, take} - {5'h00, pop};

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N)
      pend_q <= 6'h00;
    else
      pend_q <= pend_d;
  end

  reset_state_a: assert property (
    $rose(RESET_N) |-> LOW_LATENCY && !OUT_VALID)
    else $error("not in bypass state after reset");
  ready_release_a: assert property (
    $rose(RESET_N) |=> RAW_READY)
    else $error("input not ready after reset");
  raw_latency_a: assert property (
    take && LOW_LATENCY && pend_q == 6'h00 |=>
      !OUT_VALID [*8] ##1 !OUT_VALID ##1 !OUT_VALID ##1 OUT_VALID)
    else $error("raw path latency wrong");
  proc_latency_a: assert property (
    take && !LOW_LATENCY && pend_q == 6'h00 |=>
      !OUT_VALID [*8] ##1 !OUT_VALID [*6] ##1 OUT_VALID)
    else $error("processed path latency wrong");
  valid_hold_a: assert property (
    OUT_VALID && !OUT_READY |=> OUT_VALID)
    else $error("output valid dropped while stalled");
  data_hold_a: assert property (
    OUT_VALID && !OUT_READY |=> $stable(OUT_DATA))
    else $error("output data changed while stalled");
  mux_quiet_a: assert property (
    SEN_N [*8] |=> $stable(LOW_LATENCY))
    else $error("path select moved without a write");
  word_pairing_a: assert property (
    OUT_VALID |-> pend_q != 6'h00)
    else $error("output word without a sample");
endmodule // llbs_properties

bind llbs_top llbs_properties #(.DW(DW)) chk_u (
  .CLK        (CLK),
  .RESET_N    (RESET_N),
  .SCLK       (SCLK),
  .SEN_N      (SEN_N),
  .SDATA      (SDATA),
  .RAW_DATA   (RAW_DATA),
  .RAW_VALID  (RAW_VALID),
  .RAW_READY  (RAW_READY),
  .OUT_DATA   (OUT_DATA),
  .OUT_VALID  (OUT_VALID),
  .OUT_READY  (OUT_READY),
  .LOW_LATENCY(LOW_LATENCY)
);

// file: llbs_stream_if.sv
// Valid/ready word stream between the block's own modules.
`timescale 1ns/1ns
interface llbs_stream_if #(parameter int DW = 14);
  logic          valid;
  logic          ready;
  logic [DW-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// file: llbs_top.sv
// Low-latency bypass select: serial config, raw and processed paths, output.
`timescale 1ns/1ns
`include "llbs_defines.svh"
module llbs_top #(
  parameter int DW        = 14,
  parameter int DEPTH     = 16,
  parameter int LL_CYCLES = `LLBS_LL_CYCLES
) (
  input  wire logic          CLK,
  input  wire logic          RESET_N,
  input  wire logic          SCLK,
  input  wire logic          SEN_N,
  input  wire logic          SDATA,
  input  wire logic [DW-1:0] RAW_DATA,
  input  wire logic          RAW_VALID,
  output logic               RAW_READY,
  output logic      [DW-1:0] OUT_DATA,
  output logic               OUT_VALID,
  input  wire logic          OUT_READY,
  output logic               LOW_LATENCY
);
  // The take edge loads the first stage, so the FIFO write and the output
  // register bring the total to exactly LL_CYCLES edges.
  localparam int RAW_STAGES = LL_CYCLES - 1;
  localparam int PROC       = `LLBS_PROC_CYCLES;
  localparam int PW         = DW + 15;
  localparam int EW         = DW + `LLBS_EST_FRAC + 1;

  // -------------------------------------------------------------------------
  // Functions
  // -------------------------------------------------------------------------
  function automatic logic signed [DW-1:0] sat(input logic signed [PW-1:0] v);
    logic signed [PW-1:0] hi;
    logic signed [PW-1:0] lo;
    hi = PW'({1'b0, {(DW-1){1'b1}}});
    lo = -hi - PW'(1);
    if (v > hi) begin
      sat = DW'(hi);
    end else if (v < lo) begin
      sat = DW'(lo);
    end else begin
      sat = DW'(v);
    end
  endfunction

  // Gain factors in 0.5 dB steps, scaled by 2^12; codes above 6 dB hold 6 dB.
  function automatic logic signed [14:0] gain_factor(input logic [3:0] code);
    case (code)
      4'h0:    gain_factor = 15'sh1000;
      4'h1:    gain_factor = 15'sh10f4;
      4'h2:    gain_factor = 15'sh11f5;
      4'h3:    gain_factor = 15'sh1306;
      4'h4:    gain_factor = 15'sh1427;
      4'h5:    gain_factor = 15'sh1559;
      4'h6:    gain_factor = 15'sh169e;
      4'h7:    gain_factor = 15'sh17f5;
      4'h8:    gain_factor = 15'sh1962;
      4'h9:    gain_factor = 15'sh1ae3;
      4'ha:    gain_factor = 15'sh1c7c;
      4'hb:    gain_factor = 15'sh1e2c;
      default: gain_factor = 15'sh1ff7;
    endcase
  endfunction

  // -------------------------------------------------------------------------
  // Serial pin synchronisers
  // -------------------------------------------------------------------------
  logic [2:0] sclk_sync_q;
  logic [1:0] sen_sync_q;
  logic [1:0] sdata_sync_q;
  logic       sclk_rise;

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      sclk_sync_q  <= '0;
      sen_sync_q   <= 2'h3;
      sdata_sync_q <= '0;
    end else begin
      sclk_sync_q  <= {sclk_sync_q[1:0], SCLK};
      sen_sync_q   <= {sen_sync_q[0], SEN_N};
      sdata_sync_q <= {sdata_sync_q[0], SDATA};
    end
  end

  assign sclk_rise = sclk_sync_q[1] && !sclk_sync_q[2];

  // -------------------------------------------------------------------------
  // Serial receiver: address byte then data byte, MSB first
  // -------------------------------------------------------------------------
  llbs_pkg::ser_state_type ser_q;
  logic [3:0]                    bit_cnt_q;
  logic [`LLBS_XFER_BITS-1:0]    shift_q;
  logic [7:0]                    wr_addr;
  logic [7:0]                    wr_data;
  logic                          wr_stb;

  assign wr_addr = shift_q[15:8]; // R6
  assign wr_data = shift_q[7:0]; // R6
  assign wr_stb  = (ser_q == llbs_pkg::SER_COMMIT);

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ser_q     <= llbs_pkg::SER_IDLE;
      bit_cnt_q <= '0;
      shift_q   <= '0;
    end else begin
      case (ser_q)
        llbs_pkg::SER_IDLE: begin
          bit_cnt_q <= '0;
          if (!sen_sync_q[1]) begin
            ser_q <= llbs_pkg::SER_SHIFT;
          end
        end
        llbs_pkg::SER_SHIFT: begin
          if (sen_sync_q[1]) begin
            ser_q <= llbs_pkg::SER_IDLE;
          end else if (sclk_rise) begin
            shift_q   <= {shift_q[14:0], sdata_sync_q[1]}; // R6
            bit_cnt_q <= bit_cnt_q + 1'b1;
            if (bit_cnt_q == 4'hf) begin
              ser_q <= llbs_pkg::SER_COMMIT;
            end
          end
        end
        llbs_pkg::SER_COMMIT: begin
          ser_q <= llbs_pkg::SER_SHIFT;
        end
        default: begin
          ser_q <= llbs_pkg::SER_IDLE;
        end
      endcase
    end
  end

  // -------------------------------------------------------------------------
  // Configuration bits
  // -------------------------------------------------------------------------
  logic                    fast_path_off_q;
  logic [3:0]              gain_code_q;
  logic                    dc_trim_enable_q;
  logic                    freeze_q;
  logic [3:0]              tc_q;
  llbs_pkg::test_mode_type test_q;
  logic                    soft_rst;

  assign soft_rst = wr_stb && (wr_addr == `LLBS_ADDR_RESET) &&
                    wr_data[`LLBS_BIT_SRESET];

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      fast_path_off_q  <= 1'b0; // R1
      gain_code_q      <= `LLBS_GAIN_RST; // R7
      dc_trim_enable_q <= 1'b0; // R8
      freeze_q         <= 1'b0;
      tc_q             <= `LLBS_TC_RST;
      test_q           <= llbs_pkg::TP_NONE;
    end else if (soft_rst) begin
      fast_path_off_q  <= 1'b0; // R1
      gain_code_q      <= `LLBS_GAIN_RST; // R7
      dc_trim_enable_q <= 1'b0; // R8
      freeze_q         <= 1'b0;
      tc_q             <= `LLBS_TC_RST;
      test_q           <= llbs_pkg::TP_NONE;
    end else if (wr_stb) begin
      case (wr_addr)
        `LLBS_ADDR_PATH: fast_path_off_q <= wr_data[`LLBS_BIT_FPO];
        `LLBS_ADDR_GAIN: gain_code_q <= wr_data[3:0];
        `LLBS_ADDR_TRIM: begin
          dc_trim_enable_q <= wr_data[`LLBS_BIT_TRIM_EN];
          freeze_q         <= wr_data[`LLBS_BIT_FREEZE];
          tc_q             <= wr_data[`LLBS_TC_LSB +: 4];
        end
        `LLBS_ADDR_TEST: test_q <= llbs_pkg::test_mode_type'(wr_data[1:0]);
        default: begin
        end
      endcase
    end
  end

  // -------------------------------------------------------------------------
  // Raw path delay line
  // -------------------------------------------------------------------------
  logic [DW-1:0] raw_q [RAW_STAGES];
  logic          raw_v_q [RAW_STAGES];

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      for (int i = 0; i < RAW_STAGES; i++) begin
        raw_q[i]   <= '0;
        raw_v_q[i] <= 1'b0;
      end
    end else begin
      raw_q[0]   <= RAW_DATA;
      raw_v_q[0] <= RAW_VALID && RAW_READY;
      for (int i = 1; i < RAW_STAGES; i++) begin
        raw_q[i]   <= raw_q[i-1]; // R2
        raw_v_q[i] <= raw_v_q[i-1];
      end
    end
  end

  // -------------------------------------------------------------------------
  // Processed path: gain, saturate, offset trim, test pattern
  // -------------------------------------------------------------------------
  logic signed [DW-1:0] tap;
  logic signed [PW-1:0] prod_q;
  logic signed [DW-1:0] gain_q;
  logic signed [DW-1:0] trim_q;
  logic [DW-1:0]        proc_q;
  logic [DW-1:0]        ramp_q;
  logic [PROC-1:0]      pv_q;
  logic signed [EW-1:0] est_q;
  logic signed [EW-1:0] est_diff;
  logic signed [EW-1:0] corr;
  logic [4:0]           est_shift;

  assign tap       = raw_q[RAW_STAGES-1];
  assign est_diff  = (EW'(gain_q) <<< `LLBS_EST_FRAC) - est_q;
  assign corr      = est_q >>> `LLBS_EST_FRAC;
  assign est_shift = `LLBS_TC_BASE +
                     5'((tc_q > `LLBS_TC_MAX) ? `LLBS_TC_MAX : tc_q);

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      prod_q <= '0;
      gain_q <= '0;
      trim_q <= '0;
      proc_q <= '0;
      pv_q   <= '0;
    end else begin
      // Gain is live at its 0 dB code as soon as the fast path is off.
      prod_q <= PW'(tap) * PW'(gain_factor(gain_code_q)); // R7
      gain_q <= sat(prod_q >>> `LLBS_GAIN_FRAC);
      if (dc_trim_enable_q) begin
        trim_q <= sat(PW'(gain_q) - PW'(corr)); // R8
      end else begin
        trim_q <= gain_q;
      end
      case (test_q)
        llbs_pkg::TP_ZEROS: proc_q <= '0;
        llbs_pkg::TP_ONES:  proc_q <= '1;
        llbs_pkg::TP_RAMP:  proc_q <= ramp_q;
        default:            proc_q <= trim_q;
      endcase
      pv_q <= {pv_q[PROC-2:0], raw_v_q[RAW_STAGES-1]}; // R4
    end
  end

  // Estimator keeps running only while enabled and not frozen; a frozen
  // estimate keeps correcting every sample with its last value.
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      est_q <= '0;
    end else if (soft_rst || !dc_trim_enable_q) begin
      est_q <= '0; // R8
    end else if (!freeze_q && pv_q[1]) begin
      est_q <= est_q + (est_diff >>> est_shift);
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ramp_q <= '0;
    end else if (pv_q[2]) begin
      ramp_q <= ramp_q + 1'b1;
    end
  end

  // -------------------------------------------------------------------------
  // Path select, FIFO and output register
  // -------------------------------------------------------------------------
  llbs_stream_if #(.DW(DW)) fifo_in ();
  llbs_stream_if #(.DW(DW)) fifo_out ();

  // Bypass ignores every processing setting in low-latency state.
  assign fifo_in.data  = fast_path_off_q ? proc_q : tap; // R9 R3
  assign fifo_in.valid = fast_path_off_q ? pv_q[PROC-1]
                                         : raw_v_q[RAW_STAGES-1]; // R9
  assign fifo_out.ready = !OUT_VALID || OUT_READY;

  llbs_fifo #(
    .DW    (DW),
    .DEPTH (DEPTH),
    // Space drops with two words held; the rest absorbs words in flight.
    .SLACK (RAW_STAGES + PROC + 1)
  ) u_fifo (
    .clk     (CLK),
    .rst_n   (RESET_N),
    .wr      (fifo_in),
    .rd      (fifo_out),
    .space_q (RAW_READY)
  );

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      OUT_DATA  <= '0;
      OUT_VALID <= 1'b0;
    end else if (fifo_out.ready) begin
      OUT_DATA  <= fifo_out.data; // R2
      OUT_VALID <= fifo_out.valid;
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      LOW_LATENCY <= 1'b1; // R1
    end else begin
      LOW_LATENCY <= !fast_path_off_q;
    end
  end
endmodule // llbs_top

// file: testbench.sv
// Self-checking bench for the low-latency bypass select block.
`timescale 1ns/1ns
`include "llbs_defines.svh"
`define CHECK(nm, e, g) begin \
  n_compared++; \
  if ((g) !== (e)) begin \
    n_mismatch++; \
    $display("MISMATCH %s exp %0h got %0h", nm, e, g); \
  end \
end
module testbench;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [13:0] raw_data = 14'h0000;
  logic        raw_valid = 1'b0;
  logic        raw_ready;
  logic [13:0] out_data;
  logic        out_valid;
  logic        out_ready;
  logic        low_latency;
  logic        sclk;
  logic        sen_n;
  logic        sdata;
  int          n_mismatch = 0;
  int          n_compared = 0;
  int          t0;

  always #10 clk = ~clk;

  llbs_top dut_u (
    .CLK        (clk),
    .RESET_N    (rst_n),
    .SCLK       (sclk),
    .SEN_N      (sen_n),
    .SDATA      (sdata),
    .RAW_DATA   (raw_data),
    .RAW_VALID  (raw_valid),
    .RAW_READY  (raw_ready),
    .OUT_DATA   (out_data),
    .OUT_VALID  (out_valid),
    .OUT_READY  (out_ready),
    .LOW_LATENCY(low_latency)
  );

  llbs_partner partner_u (
    .clk      (clk),
    .out_data (out_data),
    .out_valid(out_valid),
    .out_ready(out_ready),
    .sclk     (sclk),
    .sen_n    (sen_n),
    .sdata    (sdata)
  );

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic send(input logic [13:0] v, output int t);
    int n;
    n = 0;
    raw_data <= v;
    raw_valid <= 1'b1;
    @(posedge clk);
    while (!raw_ready && n < 50) begin
      n++;
      @(posedge clk);
    end
    t = partner_u.cyc;
    raw_valid <= 1'b0;
    @(posedge clk);
  endtask

  // The capture samples one edge after the word appears.
  task automatic expect_word(input string nm, input logic [13:0] e,
                             input int t, input int lat);
    int n;
    n = 0;
    while (partner_u.got_q.size() == 0 && n < 100) begin
      n++;
      @(posedge clk);
    end
    `CHECK(nm, e, partner_u.got_q[0])
    `CHECK(nm, lat + 1, partner_u.at_q[0] - t)
    partner_u.got_q.delete();
    partner_u.at_q.delete();
  endtask

  task automatic t_reset;
    `CHECK("reset path", 1'b1, low_latency)
    `CHECK("reset valid", 1'b0, out_valid)
  endtask

  task automatic t_proc;
    partner_u.write(`LLBS_ADDR_PATH, 8'h01);
    `CHECK("path off", 1'b0, low_latency)
    send(14'h2345, t0);
    expect_word("unity", 14'h2345, t0,
                `LLBS_LL_CYCLES + `LLBS_PROC_CYCLES);
    // A second word would show any estimate left running after reset.
    send(14'h2345, t0);
    expect_word("trim off", 14'h2345, t0,
                `LLBS_LL_CYCLES + `LLBS_PROC_CYCLES);
    partner_u.write(`LLBS_ADDR_TEST, 8'h02);
    send(14'h0011, t0);
    expect_word("ones", 14'h3fff, t0,
                `LLBS_LL_CYCLES + `LLBS_PROC_CYCLES);
    partner_u.write(`LLBS_ADDR_RESET, 8'h01);
    `CHECK("soft reset", 1'b1, low_latency)
  endtask

  task automatic t_bypass;
    partner_u.write(`LLBS_ADDR_PATH, 8'h01);
    partner_u.write(`LLBS_ADDR_TEST, 8'h02);
    partner_u.write(`LLBS_ADDR_GAIN, 8'h0c);
    partner_u.write(`LLBS_ADDR_TRIM, 8'h01);
    partner_u.write(`LLBS_ADDR_PATH, 8'h00);
    `CHECK("path back", 1'b1, low_latency)
    send(14'h2001, t0);
    expect_word("raw", 14'h2001, t0, `LLBS_LL_CYCLES);
  endtask

  task automatic t_fill;
    int k;
    k = 0;
    partner_u.out_ready <= 1'b0;
    raw_valid <= 1'b1;
    raw_data <= 14'h0100;
    repeat (40) begin
      @(posedge clk);
      if (raw_ready) begin
        k++;
        raw_data <= 14'h0100 + 14'(k);
      end
    end
    raw_valid <= 1'b0;
    `CHECK("refused", 1'b0, raw_ready)
    partner_u.out_ready <= 1'b1;
    repeat (40) @(posedge clk);
    `CHECK("drained", k, partner_u.got_q.size())
    for (int i = 0; i < k; i++)
      `CHECK("order", 14'h0100 + 14'(i), partner_u.got_q[i])
    `CHECK("empty", 1'b1, raw_ready)
    partner_u.got_q.delete();
    partner_u.at_q.delete();
  endtask

  task automatic test_done;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_reset();
    t_proc();
    t_bypass();
    t_fill();
    test_done();
  end

  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    test_done();
  end
endmodule // testbench
